/* design/adcsq_top.sv */
/*
 eight channel SAR scan sequencer with offset compensation, result RAM,
 active low scan done line and SPI read port.
 assumes an external comparator and capacitor DAC driven by afe_ctl.
*/
`timescale 1ns/1ns
`include "adcsq_defs.svh"
// Operation
// - each input is sampled and then resolved bit by bit into a 10-bit code.
// - sampling plus conversion of one channel finishes inside 125 us.
// - channels 0-4, 6, 7 are converted every 1 ms on a fixed self-timed schedule.
// - the slot of channel 5 alternates between input 5 and the offset channel.
// - results are corrected by the offset measured on the internal channel.
// - after all eight channels the results are written to the result RAM.
// - the scan done line goes low when channel 7 conversion ends.
// - host accesses over SPI at up to 2 Mbaud with no real-time constraint.
// - serial output is high impedance when deselected or in reset.
// - the first two command bits address the device, the next three must be the read command, the last three pick the channel.
module adcsq_top
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // analog front end
    output adcsq_pkg::adcsq_afe_ctl_s afe_ctl,
    input wire logic cmp_in,
    // host side
    output logic scan_done_n,
    input wire adcsq_pkg::adcsq_spi_in_s spi_in,
    output logic miso_o,
    output logic miso_oe
);
    import adcsq_pkg::*;
    adcsq_state_e st_q;
    logic [13:0] slot_q;
    logic [13:0] step_q;
    adcsq_ch_t ch_q;
    logic comp_q;
    adcsq_code_t sar_q;
    logic [3:0] bit_q;
    adcsq_code_t offs_q;
    adcsq_code_t raw_q [`ADCSQ_NCH];
    adcsq_code_t ram_q [`ADCSQ_NCH];
    adcsq_code_t ram_rd;
    adcsq_ch_t rd_addr;
    logic rd_pulse;
    logic slot_end;
    logic conv_end;
    logic scan_start;
    adcsq_code_t corr;
    assign slot_end = (slot_q == 14'(`ADCSQ_SLOT_CYC - 1));
    assign scan_start = slot_end && (ch_q == `ADCSQ_LAST_CH);
    assign conv_end = (st_q == ADCSQ_CONVERT) && (bit_q == 4'h0)
        && (step_q == 14'h0000);
    // -----------------------------------------
    // fixed slot timer, 8 x 125 us = 1 ms
    // -----------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            slot_q <= 14'h0000;
            ch_q <= 3'h0;
            comp_q <= 1'b0;
        end
        else if (clk_en && st_q != ADCSQ_IDLE)
        begin
            if (slot_end)
            begin
                slot_q <= 14'h0000;
                ch_q <= ch_q + 3'h1;
                if (ch_q == `ADCSQ_SHARED_CH)
                    comp_q <= ~comp_q;
            end
            else
                slot_q <= slot_q + 14'h0001;
        end
    end
    // -----------------------------------------
    // sample and SAR conversion
    // -----------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= ADCSQ_IDLE;
            step_q <= 14'h0000;
            sar_q <= '0;
            bit_q <= 4'h0;
        end
        else if (clk_en)
        begin
            unique case (st_q)
                ADCSQ_IDLE, ADCSQ_WAIT:
                begin
                    if (slot_end || st_q == ADCSQ_IDLE)
                    begin
                        st_q <= ADCSQ_SAMPLE;
                        step_q <= 14'(`ADCSQ_SAMPLE_CYC - 1);
                    end
                end
                ADCSQ_SAMPLE:
                begin
                    if (step_q == 14'h0000)
                    begin
                        st_q <= ADCSQ_CONVERT;
                        bit_q <= 4'(`ADCSQ_SAR_BITS - 1);
                        sar_q <= 10'h200;
                        step_q <= 14'((`ADCSQ_CONV_CYC - `ADCSQ_SAMPLE_CYC) / 10 - 1);
                    end
                    else
                        step_q <= step_q - 14'h0001;
                end
                ADCSQ_CONVERT:
                begin
                    if (step_q != 14'h0000)
                        step_q <= step_q - 14'h0001;
                    else
                    begin
                        if (!cmp_in)
                            sar_q[bit_q] <= 1'b0;
                        if (bit_q == 4'h0)
                            st_q <= ADCSQ_WAIT;
                        else
                        begin
                            sar_q[bit_q - 4'h1] <= 1'b1;
                            bit_q <= bit_q - 4'h1;
                            step_q <= 14'((`ADCSQ_CONV_CYC - `ADCSQ_SAMPLE_CYC) / 10 - 1);
                        end
                    end
                end
            endcase
        end
    end
    // -----------------------------------------
    // raw capture, offset, correction
    // -----------------------------------------
    adcsq_code_t final_code;
    assign final_code = cmp_in ? sar_q : (sar_q & ~(10'h001));
    assign corr = (final_code > offs_q) ? final_code - offs_q : 10'h000;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            offs_q <= '0;
            for (int i = 0; i < `ADCSQ_NCH; i++)
                raw_q[i] <= '0;
        end
        else if (clk_en && conv_end)
        begin
            if (ch_q == `ADCSQ_SHARED_CH && comp_q)
                offs_q <= final_code;
            else
                raw_q[ch_q] <= corr;
        end
    end
    // -----------------------------------------
    // result RAM, written once per scan
    // -----------------------------------------
    logic copy_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            copy_q <= 1'b0;
        else if (clk_en)
            copy_q <= conv_end && (ch_q == `ADCSQ_LAST_CH);
    end
    generate
        for (genvar g = 0; g < `ADCSQ_NCH; g++)
        begin : g_ram
            always_ff @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                    ram_q[g] <= '0;
                else if (clk_en && copy_q)
                    ram_q[g] <= raw_q[g];
            end
        end
    endgenerate
    assign ram_rd = ram_q[rd_addr];
    // -----------------------------------------
    // scan done line
    // -----------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            scan_done_n <= 1'b1;
        else if (clk_en)
        begin
            if (copy_q)
                scan_done_n <= 1'b0;
            else if (scan_start || rd_pulse)
                scan_done_n <= 1'b1;
        end
    end
    always_comb
    begin
        afe_ctl.ch = ch_q;
        afe_ctl.comp_sel = (ch_q == `ADCSQ_SHARED_CH) && comp_q;
        afe_ctl.sample = (st_q == ADCSQ_SAMPLE);
        afe_ctl.trial = sar_q;
    end
    // -----------------------------------------
    // SPI read port
    // -----------------------------------------
    adcsq_spi_slave u_spi
    (
        .mclk(mclk),
        .rstn(rstn),
        .clk_en(clk_en),
        .spi_in(spi_in),
        .miso_o(miso_o),
        .miso_oe(miso_oe),
        .rd_addr(rd_addr),
        .rd_data(ram_rd),
        .rd_pulse(rd_pulse)
    );
    // -----------------------------------------
    // checks
    // -----------------------------------------
    conv_in_slot_a: assert property (@(posedge mclk) disable iff (!rstn)
        conv_end |-> slot_q < 14'(`ADCSQ_CONV_CYC))
        else $error("conversion past slot");
    slot_period_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && slot_end |=> slot_q == 14'h0000)
        else $error("slot timer not restarted");
    shared_alt_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && slot_end && ch_q == `ADCSQ_SHARED_CH |=> comp_q != $past(comp_q))
        else $error("shared slot did not alternate");
    irq_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && conv_end && ch_q == `ADCSQ_LAST_CH && !scan_start
        ##1 clk_en |=> !scan_done_n)
        else $error("scan done not asserted");
    ram_copy_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && copy_q |=> ram_q[0] == $past(raw_q[0]))
        else $error("result ram not written");
    irq_rel_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && rd_pulse && !copy_q |=> scan_done_n)
        else $error("scan done not released");
    offs_corr_a: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && conv_end && afe_ctl.comp_sel |=> offs_q == $past(final_code))
        else $error("offset not captured");
    sample_first_a: assert property (@(posedge mclk) disable iff (!rstn)
        st_q == ADCSQ_CONVERT |-> $past(st_q) != ADCSQ_IDLE)
        else $error("convert without sample");
    irq_cov_c: cover property (@(posedge mclk) disable iff (!rstn) $fell(scan_done_n));
    offs_cov_c: cover property (@(posedge mclk) disable iff (!rstn) conv_end && afe_ctl.comp_sel);
    read_cov_c: cover property (@(posedge mclk) disable iff (!rstn) rd_pulse);
endmodule

/* design/adcsq_defs.svh */
/*
 constants of the scan sequencer: timing counts, widths, SPI framing.
 assumes mclk at 100 MHz; included by the package and the design files.
*/
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH
`define ADCSQ_CLK_MHZ 100
`define ADCSQ_SLOT_US 125
`define ADCSQ_SLOT_CYC (`ADCSQ_SLOT_US * `ADCSQ_CLK_MHZ)
`define ADCSQ_CONV_US 122
`define ADCSQ_CONV_CYC (`ADCSQ_CONV_US * `ADCSQ_CLK_MHZ)
`define ADCSQ_SAMPLE_CYC 200
`define ADCSQ_SAR_BITS 10
`define ADCSQ_NCH 8
`define ADCSQ_SHARED_CH 3'h5
`define ADCSQ_LAST_CH 3'h7
`define ADCSQ_DEV_ADDR 2'h0
`define ADCSQ_SPI_CMD_BITS 8
`define ADCSQ_SPI_DATA_BITS 16
`define ADCSQ_CMD_READ 3'h1
`endif

/* design/adcsq_pkg.sv */
/*
 types of the scan sequencer.
 assumes adcsq_defs.svh on the include path.
*/
`include "adcsq_defs.svh"
package adcsq_pkg;
    typedef logic [`ADCSQ_SAR_BITS-1:0] adcsq_code_t;
    typedef logic [2:0] adcsq_ch_t;
    typedef enum logic [1:0]
    {
        ADCSQ_IDLE = 2'h0,
        ADCSQ_SAMPLE = 2'h1,
        ADCSQ_CONVERT = 2'h3,
        ADCSQ_WAIT = 2'h2
    } adcsq_state_e;
    // analog front end control and answer
    typedef struct packed
    {
        adcsq_ch_t ch;
        logic comp_sel;
        logic sample;
        adcsq_code_t trial;
    } adcsq_afe_ctl_s;
    typedef struct packed
    {
        logic sck;
        logic mosi;
        logic ss_n;
    } adcsq_spi_in_s;
endpackage

/* design/adcsq_spi_slave.sv */
/*
 SPI slave (mode 0) reading the result RAM: command byte, then 16 data bits.
 assumes SPI pins synchronous to mclk, SCK at most 2 MHz.
*/
`timescale 1ns/1ns
`include "adcsq_defs.svh"
module adcsq_spi_slave
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // pins
    input wire adcsq_pkg::adcsq_spi_in_s spi_in,
    output logic miso_o,
    output logic miso_oe,
    // ram port
    output adcsq_pkg::adcsq_ch_t rd_addr,
    input wire adcsq_pkg::adcsq_code_t rd_data,
    output logic rd_pulse
);
    import adcsq_pkg::*;
    logic sck_q;
    logic [4:0] cnt_q;
    logic [7:0] cmd_q;
    logic [15:0] sh_q;
    logic sel_q;
    logic rise;
    logic fall;
    assign rise = spi_in.sck & ~sck_q;
    assign fall = ~spi_in.sck & sck_q;
    assign rd_addr = cmd_q[2:0];
    // -----------------------------------------
    // frame counter and command capture
    // -----------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_q <= 1'b0;
            cnt_q <= 5'h00;
            cmd_q <= 8'h00;
        end
        else if (clk_en)
        begin
            sck_q <= spi_in.sck;
            if (spi_in.ss_n)
                cnt_q <= 5'h00;
            else if (rise)
            begin
                if (cnt_q < 5'(`ADCSQ_SPI_CMD_BITS))
                    cmd_q <= {cmd_q[6:0], spi_in.mosi};
                if (cnt_q != 5'h18)
                    cnt_q <= cnt_q + 5'h01;
            end
        end
    end
    // -----------------------------------------
    // address match, shift out, ram read strobe
    // -----------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sh_q <= 16'h0000;
            sel_q <= 1'b0;
            rd_pulse <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_pulse <= 1'b0;
            if (spi_in.ss_n)
                sel_q <= 1'b0;
            else if (fall && cnt_q == 5'(`ADCSQ_SPI_CMD_BITS))
            begin
                sel_q <= (cmd_q[7:6] == `ADCSQ_DEV_ADDR) && (cmd_q[5:3] == `ADCSQ_CMD_READ);
                rd_pulse <= (cmd_q[7:6] == `ADCSQ_DEV_ADDR) && (cmd_q[5:3] == `ADCSQ_CMD_READ);
                sh_q <= {6'h00, rd_data};
            end
            else if (fall && cnt_q > 5'(`ADCSQ_SPI_CMD_BITS))
                sh_q <= {sh_q[14:0], 1'b0};
        end
    end
    assign miso_oe = sel_q & ~spi_in.ss_n & rstn;
    assign miso_o = sh_q[15];
    miso_hiz_a: assert property (@(posedge mclk) disable iff (!rstn)
        spi_in.ss_n |-> !miso_oe)
        else $error("miso driven while deselected");
endmodule

/* tb/adcsq_spi_host.sv */
/*
 host model: SPI master, mode 0, 2 MHz, one command byte then 16 read bits.
 assumes mclk at 100 MHz from the testbench; sck stands low outside frames.
*/
`timescale 1ns/1ns
module adcsq_spi_host
(
    // clock
    input wire logic mclk,
    // pins
    output adcsq_pkg::adcsq_spi_in_s spi_in,
    input wire logic miso_o,
    input wire logic miso_oe
);
    import adcsq_pkg::*;
    logic last_q;
    initial
    begin
        spi_in = '{sck: 1'b0, mosi: 1'b0, ss_n: 1'b1};
        last_q = 1'b0;
    end
    // ------------------------------
    // frame
    // ------------------------------
    task automatic half();
        repeat (25) @(posedge mclk);
    endtask
    task automatic xfer(input logic [7:0] cmd, output logic [15:0] rx);
        logic b;
        rx = 16'h0000;
        spi_in.ss_n <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            spi_in.mosi <= (i < 8) ? cmd[7 - i] : 1'b0;
            half();
            b = miso_oe ? miso_o : ~last_q;
            last_q = b;
            if (i >= 8)
                rx[23 - i] = b;
            spi_in.sck <= 1'b1;
            half();
            spi_in.sck <= 1'b0;
        end
        half();
        spi_in.ss_n <= 1'b1;
        half();
    endtask
endmodule

/* tb/testbench.sv */
/*
 testbench of the scan sequencer: one scan, result reads, resets.
 assumes adcsq_defs.svh on the include path; comparator modelled here.
*/
`timescale 1ns/1ns
`include "adcsq_defs.svh"
module testbench;
    import adcsq_pkg::*;
    localparam int SLOT = `ADCSQ_SLOT_CYC;
    localparam int CONV = 10400;
    localparam int OFFV = 3;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic cmp_in = 1'b0;
    adcsq_afe_ctl_s afe_ctl;
    logic scan_done_n;
    logic miso_o;
    logic miso_oe;
    adcsq_spi_in_s spi_in;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int last_start = -1;
    logic [2:0] exp_ch = 3'h0;
    logic sample_d = 1'b0;
    logic ss_d = 1'b1;
    logic off_seen = 1'b0;
    logic exp_comp = 1'b0;
    logic oe_seen = 1'b0;
    adcsq_code_t ana [8] = '{10'h3FF, 10'h000, 10'h155, 10'h2AA,
        10'h201, 10'h1FF, 10'h002, 10'h123};
    always #5 mclk = ~mclk;
    adcsq_top i_adcsq_top (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .afe_ctl(afe_ctl),
        .cmp_in(cmp_in), .scan_done_n(scan_done_n), .spi_in(spi_in), .miso_o(miso_o),
        .miso_oe(miso_oe));
    adcsq_spi_host i_adcsq_spi_host (.mclk(mclk), .spi_in(spi_in), .miso_o(miso_o),
        .miso_oe(miso_oe));
    // ------------------------------
    // comparator and monitor
    // ------------------------------
    always @(posedge mclk)
        cmp_in <= ((afe_ctl.comp_sel ? OFFV : int'(ana[afe_ctl.ch])) >= int'(afe_ctl.trial));
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        sample_d <= afe_ctl.sample;
        ss_d <= spi_in.ss_n;
        if (miso_oe === 1'b1)
            oe_seen <= 1'b1;
        if (!rstn)
        begin
            exp_ch <= 3'h0;
            last_start <= -1;
            exp_comp <= 1'b0;
        end
        else if (afe_ctl.sample && !sample_d)
        begin
            chk_word("slot_ch", 16'(exp_ch), 16'(afe_ctl.ch));
            if (last_start >= 0)
                chk_word("slot_len", 16'(SLOT), 16'(cyc - last_start));
            chk_bit("comp_sel", (exp_ch == 3'h5) && exp_comp, afe_ctl.comp_sel);
            if (exp_ch == 3'h5)
                exp_comp <= ~exp_comp;
            if (exp_ch == 3'h5)
                off_seen <= afe_ctl.comp_sel;
            last_start <= cyc;
            exp_ch <= exp_ch + 3'h1;
        end
        if (spi_in.ss_n && ss_d)
            chk_bit("oe_idle", 1'b0, miso_oe);
    end
    // ------------------------------
    // compare and close
    // ------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] exp_code(input int c);
        int v;
        v = int'(ana[c]);
        if (c > 5 && off_seen)
            v = (v > OFFV) ? v - OFFV : 0;
        return 16'(v);
    endfunction
    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset();
        repeat (6) @(posedge mclk);
        chk_bit("rst_done", 1'b1, scan_done_n);
        chk_bit("rst_oe", 1'b0, miso_oe);
        rstn <= 1'b1;
        repeat (100) @(posedge mclk);
        clk_en <= 1'b0;
        repeat (150) @(posedge mclk);
        chk_bit("freeze_sample", 1'b1, afe_ctl.sample);
        clk_en <= 1'b1;
        repeat (50) @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_bit("rst_sample", 1'b0, afe_ctl.sample);
        chk_word("rst_ch", 16'h0000, 16'(afe_ctl.ch));
        chk_bit("rst_done2", 1'b1, scan_done_n);
        rstn <= 1'b1;
    endtask
    task automatic t_scan();
        int n;
        n = 0;
        while (scan_done_n !== 1'b0 && n < 9 * SLOT)
        begin
            @(posedge mclk);
            n++;
        end
        chk_bit("done_low", 1'b0, scan_done_n);
        chk_word("done_ch", 16'h0007, 16'(afe_ctl.ch));
        chk_bit("done_time", 1'b1, (cyc - last_start) >= CONV && (cyc - last_start) < SLOT);
    endtask
    task automatic t_read();
        logic [15:0] rx;
        i_adcsq_spi_host.xfer(8'h08, rx);
        chk_word("res_ch0", exp_code(0), rx);
        chk_bit("done_rel", 1'b1, scan_done_n);
        oe_seen = 1'b0;
        i_adcsq_spi_host.xfer(8'h48, rx);
        chk_bit("oe_foreign", 1'b0, oe_seen);
        for (int c = 1; c < 8; c++)
        begin
            i_adcsq_spi_host.xfer(8'h08 | 8'(c), rx);
            if (c != 5 || !off_seen)
                chk_word("res_ch", exp_code(c), rx);
        end
    endtask
    initial
    begin
        repeat (130000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        t_reset();
        t_scan();
        t_read();
        end_of_test();
    end
endmodule
